// *** src/srs_pkg.sv ***
// package: constants, states and helpers of the system reset sequencer
package srs_pkg;
    // ---------------------------------------------------------------
    // control word and field widths
    // ---------------------------------------------------------------
    localparam logic [7:0] SRS_CTRL_KEY   = 8'ha5;
    localparam int         SRS_EXP_W      = 4;
    localparam int         SRS_PCNT_W     = 17;
    localparam int         SRS_CAUSE_W    = 3;

    // ---------------------------------------------------------------
    // timing counts in slow-clock cycles
    // ---------------------------------------------------------------
    localparam logic [7:0] SRS_STARTUP_CYC = 8'h40;
    localparam logic [1:0] SRS_HOLD_CYC    = 2'h3;
    localparam logic [1:0] SRS_HOLD_LAST   = SRS_HOLD_CYC - 2'h1;

    // ---------------------------------------------------------------
    // reset cause codes
    // ---------------------------------------------------------------
    localparam logic [2:0] SRS_CAUSE_POR  = 3'h0;
    localparam logic [2:0] SRS_CAUSE_WDG  = 3'h2;
    localparam logic [2:0] SRS_CAUSE_SW   = 3'h3;
    localparam logic [2:0] SRS_CAUSE_USER = 3'h4;
    localparam logic [2:0] SRS_CAUSE_BOD  = 3'h5;

    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        SRS_ST_STARTUP = 3'h0,
        SRS_ST_RUN     = 3'h1,
        SRS_ST_USER    = 3'h3,
        SRS_ST_SOFT    = 3'h5,
        SRS_ST_BOD     = 3'h7
    } srs_state_t;

    // pulse length minus one: 2^(exp+1) - 1
    function automatic logic [SRS_PCNT_W-1:0] srs_pulse_last(
        input logic [SRS_EXP_W-1:0] exp
    );
        logic [SRS_PCNT_W-1:0] len;
        len = SRS_PCNT_W'(1) << ({1'b0, exp} + 5'h1); // wide sum: exp 15 must not wrap
        return len - SRS_PCNT_W'(1);
    endfunction
endpackage

// *** src/srs_pulse.sv ***
// module: pin pulse shaper, holds busy for 2^(exp+1) cycles
`timescale 1ns/1ps
module srs_pulse (
    // clock and reset
    input  wire logic  sys_clk_i,
    input  wire logic  sys_rst_i,
    input  wire logic  clk_en_i,
    // sequencer side
    srs_pulse_if.pls   pls
);
    logic [srs_pkg::SRS_PCNT_W-1:0] cnt_reg;
    logic                           busy_reg;

    assign pls.busy = busy_reg;

    // ---------------------------------------------------------------
    // length counter
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (pls.start) begin
                cnt_reg  <= srs_pkg::srs_pulse_last(pls.exp);
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (cnt_reg == '0) begin
                    busy_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg - srs_pkg::SRS_PCNT_W'(1);
                end
            end
        end
    end
endmodule

// *** src/srs_pulse_if.sv ***
// interface: link between sequencer and pin pulse shaper
`timescale 1ns/1ps
interface srs_pulse_if;
    logic                             start;
    logic [srs_pkg::SRS_EXP_W-1:0]    exp;
    logic                             busy;

    modport drv (output start, output exp, input busy);
    modport pls (input start, input exp, output busy);
endinterface

// *** src/srs_top.sv ***
// module: system reset sequencer top level
`timescale 1ns/1ps
module srs_top (
    // clock, reset, enable
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    // supply and brownout monitor
    input  wire logic        core_supply_ok_i,
    input  wire logic        brownout_req_i,
    input  wire logic        brownout_rst_en_i,
    // mode bits
    input  wire logic        pin_reset_enable_i,
    input  wire logic        pin_event_irq_enable_i,
    input  wire logic        brownout_irq_enable_i,
    input  wire logic [3:0]  pulse_length_exp_i,
    // control write
    input  wire logic        ctrl_wr_i,
    input  wire logic [7:0]  ctrl_key_i,
    input  wire logic        cmd_cpu_reset_i,
    input  wire logic        cmd_periph_reset_i,
    input  wire logic        cmd_pin_reset_i,
    // status read strobe
    input  wire logic        status_rd_i,
    // open-drain reset pin
    input  wire logic        pin_in_i,
    output logic             pin_out_o,
    output logic             pin_oe_o,
    // reset outputs, active low
    output logic             cpu_rst_n_o,
    output logic             periph_rst_n_o,
    // status
    output logic             pin_level_bit_o,
    output logic             pin_event_flag_o,
    output logic             brownout_flag_o,
    output logic [2:0]       reset_cause_o,
    output logic             cmd_in_progress_o,
    output logic             irq_o
);
    srs_pkg::srs_state_t state_reg;
    srs_pkg::srs_state_t state_next;
    logic        rst_all;
    logic        pin_s1_reg;
    logic        pin_s2_reg;
    logic        pin_prev_reg;
    logic        bod_s1_reg;
    logic        bod_s2_reg;
    logic        bod_prev_reg;
    logic [7:0]  start_cnt_reg;
    logic [1:0]  hold_cnt_reg;
    logic [1:0]  hold_cnt_next;
    logic        sw_cpu_reg;
    logic        sw_per_reg;
    logic        busy_reg;
    logic        mask_reg;
    logic        cpu_rst_n_reg;
    logic        per_rst_n_reg;
    logic        oe_reg;
    logic        lvl_reg;
    logic        pin_flag_reg;
    logic        bod_flag_reg;
    logic [2:0]  cause_reg;
    logic        irq_reg;
    logic        wr_ok;
    logic        bod_hit;
    logic        user_hit;
    logic        pin_fall;
    logic        bod_rise;
    logic        hold_done;

    srs_pulse_if pif ();

    srs_pulse u_pulse (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (rst_all),
        .clk_en_i  (clk_en_i),
        .pls       (pif)
    );

    // ---------------------------------------------------------------
    // request decoding
    // ---------------------------------------------------------------
    assign rst_all   = sys_rst_i | ~core_supply_ok_i;
    assign wr_ok     = ctrl_wr_i && (ctrl_key_i == srs_pkg::SRS_CTRL_KEY)
                       && !busy_reg
                       && (cmd_cpu_reset_i | cmd_periph_reset_i | cmd_pin_reset_i);
    assign bod_hit   = bod_s2_reg & brownout_rst_en_i;
    assign user_hit  = !pin_s2_reg && !mask_reg
                       && pin_reset_enable_i && !pin_event_irq_enable_i;
    assign pin_fall  = pin_prev_reg & ~pin_s2_reg;
    assign bod_rise  = bod_s2_reg & ~bod_prev_reg;
    assign hold_done = (hold_cnt_reg == srs_pkg::SRS_HOLD_LAST);
    assign pif.exp   = pulse_length_exp_i;

    // ---------------------------------------------------------------
    // input synchronisers and edge history
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            pin_s1_reg   <= 1'b1;
            pin_s2_reg   <= 1'b1;
            pin_prev_reg <= 1'b1;
            bod_s1_reg   <= 1'b0;
            bod_s2_reg   <= 1'b0;
            bod_prev_reg <= 1'b0;
        end else if (clk_en_i) begin
            pin_s1_reg   <= pin_in_i;
            pin_s2_reg   <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
            bod_s1_reg   <= brownout_req_i;
            bod_s2_reg   <= bod_s1_reg;
            bod_prev_reg <= bod_s2_reg;
        end
    end

    // ---------------------------------------------------------------
    // next state, priority brownout > software > user
    // ---------------------------------------------------------------
    always_comb begin
        state_next    = state_reg;
        hold_cnt_next = '0;
        pif.start     = 1'b0;
        unique case (state_reg)
            srs_pkg::SRS_ST_STARTUP: begin
                if (start_cnt_reg == srs_pkg::SRS_STARTUP_CYC) begin
                    state_next = srs_pkg::SRS_ST_RUN;
                end
            end
            srs_pkg::SRS_ST_RUN: begin
                if (bod_hit) begin
                    state_next = srs_pkg::SRS_ST_BOD;
                    pif.start  = 1'b1;
                end else if (wr_ok) begin
                    state_next = srs_pkg::SRS_ST_SOFT;
                    pif.start  = cmd_pin_reset_i;
                end else if (user_hit) begin
                    state_next = srs_pkg::SRS_ST_USER;
                end
            end
            srs_pkg::SRS_ST_USER: begin
                if (bod_hit) begin
                    state_next = srs_pkg::SRS_ST_BOD;
                    pif.start  = 1'b1;
                end else if (pin_s2_reg) begin
                    hold_cnt_next = hold_cnt_reg + 2'h1;
                    if (hold_done) begin
                        state_next = srs_pkg::SRS_ST_RUN;
                    end
                end
            end
            srs_pkg::SRS_ST_SOFT: begin
                hold_cnt_next = hold_cnt_reg + 2'h1;
                if (bod_hit) begin
                    state_next    = srs_pkg::SRS_ST_BOD;
                    hold_cnt_next = '0;
                    pif.start     = 1'b1;
                end else if (hold_done) begin
                    state_next = srs_pkg::SRS_ST_RUN;
                end
            end
            srs_pkg::SRS_ST_BOD: begin
                if (!bod_s2_reg) begin
                    hold_cnt_next = hold_cnt_reg + 2'h1;
                    if (hold_done) begin
                        state_next = srs_pkg::SRS_ST_RUN;
                    end
                end
            end
            default: begin
                state_next = srs_pkg::SRS_ST_STARTUP;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // state, startup and hold counters
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            state_reg     <= srs_pkg::SRS_ST_STARTUP;
            start_cnt_reg <= '0;
            hold_cnt_reg  <= '0;
        end else if (clk_en_i) begin
            state_reg    <= state_next;
            hold_cnt_reg <= hold_cnt_next;
            if (state_reg == srs_pkg::SRS_ST_STARTUP) begin
                start_cnt_reg <= start_cnt_reg + 8'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // software command capture and busy flag
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            sw_cpu_reg <= 1'b0;
            sw_per_reg <= 1'b0;
            busy_reg   <= 1'b0;
        end else if (clk_en_i) begin
            if (state_next == srs_pkg::SRS_ST_SOFT
                    && state_reg == srs_pkg::SRS_ST_RUN) begin
                sw_cpu_reg <= cmd_cpu_reset_i;
                sw_per_reg <= cmd_periph_reset_i;
                busy_reg   <= 1'b1;
            end else if (state_reg == srs_pkg::SRS_ST_SOFT
                    && state_next != srs_pkg::SRS_ST_SOFT) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // self-driven pin mask, cleared once pin seen high after drive
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            mask_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (pif.start || pif.busy || oe_reg) begin
                mask_reg <= 1'b1;
            end else if (pin_s2_reg) begin
                mask_reg <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // reset output flops, forced low at once on supply loss
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge core_supply_ok_i) begin
        if (!core_supply_ok_i) begin
            cpu_rst_n_reg <= 1'b0;
            per_rst_n_reg <= 1'b0;
            oe_reg        <= 1'b1;
        end else if (sys_rst_i) begin
            cpu_rst_n_reg <= 1'b0;
            per_rst_n_reg <= 1'b0;
            oe_reg        <= 1'b0;
        end else if (clk_en_i) begin
            unique case (state_next)
                srs_pkg::SRS_ST_RUN: begin
                    cpu_rst_n_reg <= 1'b1;
                    per_rst_n_reg <= 1'b1;
                end
                srs_pkg::SRS_ST_SOFT: begin
                    if (state_reg == srs_pkg::SRS_ST_SOFT) begin
                        cpu_rst_n_reg <= ~sw_cpu_reg;
                        per_rst_n_reg <= ~sw_per_reg;
                    end else begin
                        cpu_rst_n_reg <= ~cmd_cpu_reset_i;
                        per_rst_n_reg <= ~cmd_periph_reset_i;
                    end
                end
                default: begin
                    cpu_rst_n_reg <= 1'b0;
                    per_rst_n_reg <= 1'b0;
                end
            endcase
            oe_reg <= pif.busy;
        end
    end

    // ---------------------------------------------------------------
    // reset cause, loaded only on cpu reset release
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            cause_reg <= srs_pkg::SRS_CAUSE_POR;
        end else if (clk_en_i && state_next == srs_pkg::SRS_ST_RUN) begin
            unique case (state_reg)
                srs_pkg::SRS_ST_STARTUP: cause_reg <= srs_pkg::SRS_CAUSE_POR;
                srs_pkg::SRS_ST_USER:    cause_reg <= srs_pkg::SRS_CAUSE_USER;
                srs_pkg::SRS_ST_BOD:     cause_reg <= srs_pkg::SRS_CAUSE_BOD;
                srs_pkg::SRS_ST_SOFT: begin
                    if (sw_cpu_reg) begin
                        cause_reg <= srs_pkg::SRS_CAUSE_SW;
                    end
                end
                default: begin
                    cause_reg <= cause_reg;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // sticky flags, set wins over read clear; interrupt
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            lvl_reg      <= 1'b1;
            pin_flag_reg <= 1'b0;
            bod_flag_reg <= 1'b0;
            irq_reg      <= 1'b0;
        end else if (clk_en_i) begin
            lvl_reg <= pin_s2_reg;
            if (pin_fall) begin
                pin_flag_reg <= 1'b1;
            end else if (status_rd_i) begin
                pin_flag_reg <= 1'b0;
            end
            if (bod_rise && !brownout_rst_en_i) begin
                bod_flag_reg <= 1'b1;
            end else if (status_rd_i) begin
                bod_flag_reg <= 1'b0;
            end
            irq_reg <= (pin_flag_reg & pin_event_irq_enable_i)
                       | (bod_flag_reg & brownout_irq_enable_i);
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign pin_out_o         = 1'b0;
    assign pin_oe_o          = oe_reg;
    assign cpu_rst_n_o       = cpu_rst_n_reg;
    assign periph_rst_n_o    = per_rst_n_reg;
    assign pin_level_bit_o   = lvl_reg;
    assign pin_event_flag_o  = pin_flag_reg;
    assign brownout_flag_o   = bod_flag_reg;
    assign reset_cause_o     = cause_reg;
    assign cmd_in_progress_o = busy_reg;
    assign irq_o             = irq_reg;
endmodule

// *** verif/srs_pin_model.sv ***
// partner model: open-drain system reset line with pull-up and outside driver
`timescale 1ns/1ps
module srs_pin_model (
    // drivers of the line
    input  wire logic pin_oe_i,
    input  wire logic ext_hold_i,
    // resolved level
    output logic      pin_o
);
    // released line returns high through the pull-up
    assign pin_o = !(pin_oe_i || ext_hold_i);
endmodule

// *** verif/srs_top_chk.sv ***
// checker: concurrent properties on the reset sequencer ports
`timescale 1ns/1ps
module srs_top_chk (
    // clock and reset
    input wire logic       sys_clk_i,
    input wire logic       sys_rst_i,
    input wire logic       clk_en_i,
    // inputs watched
    input wire logic       core_supply_ok_i,
    input wire logic       brownout_req_i,
    input wire logic       brownout_rst_en_i,
    input wire logic       pin_event_irq_enable_i,
    input wire logic       brownout_irq_enable_i,
    input wire logic [3:0] pulse_length_exp_i,
    input wire logic       ctrl_wr_i,
    input wire logic [7:0] ctrl_key_i,
    input wire logic       cmd_cpu_reset_i,
    input wire logic       pin_in_i,
    // outputs watched
    input wire logic       pin_oe_o,
    input wire logic       cpu_rst_n_o,
    input wire logic       periph_rst_n_o,
    input wire logic       pin_level_bit_o,
    input wire logic       pin_event_flag_o,
    input wire logic       brownout_flag_o,
    input wire logic [2:0] reset_cause_o,
    input wire logic       cmd_in_progress_o,
    input wire logic       irq_o
);
    logic [16:0] hi_cnt;
    logic        hi_bad;
    logic [1:0]  age;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i || !core_supply_ok_i);
    // drive length; a pulse touched by supply loss is not judged
    always_ff @(posedge sys_clk_i) begin
        hi_cnt <= pin_oe_o ? hi_cnt + 17'h1 : 17'h0;
        hi_bad <= sys_rst_i || !core_supply_ok_i || (pin_oe_o && hi_bad);
    end
    // clean cycles since reset, saturating at three
    always_ff @(posedge sys_clk_i) begin
        age <= (sys_rst_i || !core_supply_ok_i || !clk_en_i) ? 2'h0 : age + 2'(age != 2'h3);
    end
    property p_supply;
        disable iff (sys_rst_i) !core_supply_ok_i |-> !cpu_rst_n_o && !periph_rst_n_o && pin_oe_o;
    endproperty
    property p_soft;
        ctrl_wr_i && ctrl_key_i == srs_pkg::SRS_CTRL_KEY && cmd_cpu_reset_i && !cmd_in_progress_o
            && cpu_rst_n_o && periph_rst_n_o |=> (!cpu_rst_n_o && cmd_in_progress_o)[*3]
            ##1 (cpu_rst_n_o && reset_cause_o == srs_pkg::SRS_CAUSE_SW);
    endproperty
    property p_key;
        ctrl_wr_i && ctrl_key_i != srs_pkg::SRS_CTRL_KEY && !cmd_in_progress_o && cpu_rst_n_o
            |=> !cmd_in_progress_o && cpu_rst_n_o;
    endproperty
    property p_busy;
        $rose(cmd_in_progress_o) |-> cmd_in_progress_o[*3] ##1 !cmd_in_progress_o;
    endproperty
    property p_pulse;
        $fell(pin_oe_o) && !hi_bad |-> hi_cnt == (17'h1 << ({1'b0, pulse_length_exp_i} + 5'h1));
    endproperty
    property p_level;
        age == 2'h3 |-> pin_level_bit_o == $past(pin_in_i, 3);
    endproperty
    property p_cause;
        !$stable(reset_cause_o) |-> $rose(cpu_rst_n_o);
    endproperty
    property p_birq;
        brownout_flag_o && brownout_irq_enable_i |=> irq_o;
    endproperty
    property p_pirq;
        pin_event_flag_o && pin_event_irq_enable_i |=> irq_o;
    endproperty
    property p_bodoff;
        brownout_req_i && !brownout_rst_en_i && cpu_rst_n_o |=> cpu_rst_n_o;
    endproperty
    a_supply: assert property (p_supply) else $error("resets not forced at supply loss");
    a_soft: assert property (p_soft) else $error("software reset timing wrong");
    a_key: assert property (p_key) else $error("write with bad key took effect");
    a_busy: assert property (p_busy) else $error("busy flag length wrong");
    a_pulse: assert property (p_pulse) else $error("pin pulse length wrong");
    a_level: assert property (p_level) else $error("pin level bit wrong");
    a_cause: assert property (p_cause) else $error("cause changed off release");
    a_birq: assert property (p_birq) else $error("brownout interrupt missing");
    a_pirq: assert property (p_pirq) else $error("pin interrupt missing");
    a_bodoff: assert property (p_bodoff) else $error("disabled brownout reset");
    c_soft: cover property ($rose(cpu_rst_n_o) && reset_cause_o == srs_pkg::SRS_CAUSE_SW);
    c_user: cover property ($rose(cpu_rst_n_o) && reset_cause_o == srs_pkg::SRS_CAUSE_USER);
    c_bod: cover property ($rose(cpu_rst_n_o) && reset_cause_o == srs_pkg::SRS_CAUSE_BOD);
endmodule
bind srs_top srs_top_chk i_srs_top_chk (.sys_clk_i, .sys_rst_i, .clk_en_i, .core_supply_ok_i,
    .brownout_req_i, .brownout_rst_en_i, .pin_event_irq_enable_i, .brownout_irq_enable_i,
    .pulse_length_exp_i, .ctrl_wr_i, .ctrl_key_i, .cmd_cpu_reset_i, .pin_in_i, .pin_oe_o,
    .cpu_rst_n_o, .periph_rst_n_o, .pin_level_bit_o, .pin_event_flag_o, .brownout_flag_o,
    .reset_cause_o, .cmd_in_progress_o, .irq_o);

// *** verif/testbench.sv ***
// testbench: directed and random checks of the system reset sequencer
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [2:0] cause; int lo; int hi;} srs_tb_exp_t;
    logic       sys_clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, core_supply_ok_i = 1'b1;
    logic       brownout_req_i = 1'b0, brownout_rst_en_i = 1'b0, pin_reset_enable_i = 1'b1;
    logic       pin_event_irq_enable_i = 1'b0, brownout_irq_enable_i = 1'b0;
    logic [3:0] pulse_length_exp_i = 4'h0;
    logic       ctrl_wr_i = 1'b0, cmd_cpu_reset_i = 1'b0, cmd_periph_reset_i = 1'b0;
    logic       cmd_pin_reset_i = 1'b0, status_rd_i = 1'b0, ext_hold = 1'b0, cpu_prev = 1'b1;
    logic [7:0] ctrl_key_i = 8'h00;
    logic       pin_in_i, pin_out_o, pin_oe_o, cpu_rst_n_o, periph_rst_n_o, pin_level_bit_o;
    logic       pin_event_flag_o, brownout_flag_o, cmd_in_progress_o, irq_o;
    logic [2:0] reset_cause_o;
    int         cyc = 0, mismatches = 0, num_checks = 0, hold_len;
    srs_tb_exp_t exp_q[$];
    srs_tb_exp_t e;
    srs_top i_srs_top (.sys_clk_i, .sys_rst_i, .clk_en_i, .core_supply_ok_i, .brownout_req_i,
        .brownout_rst_en_i, .pin_reset_enable_i, .pin_event_irq_enable_i,
        .brownout_irq_enable_i, .pulse_length_exp_i, .ctrl_wr_i, .ctrl_key_i, .cmd_cpu_reset_i,
        .cmd_periph_reset_i, .cmd_pin_reset_i, .status_rd_i, .pin_in_i, .pin_out_o, .pin_oe_o,
        .cpu_rst_n_o, .periph_rst_n_o, .pin_level_bit_o, .pin_event_flag_o, .brownout_flag_o,
        .reset_cause_o, .cmd_in_progress_o, .irq_o);
    srs_pin_model i_srs_pin_model (.pin_oe_i(pin_oe_o), .ext_hold_i(ext_hold), .pin_o(pin_in_i));
    // clock and edge count
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) cyc <= cyc + 1;
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic ctrl_write(input logic [7:0] k, input logic [2:0] cmd);
        @(posedge sys_clk_i);
        ctrl_wr_i <= 1'b1;
        ctrl_key_i <= k;
        {cmd_pin_reset_i, cmd_periph_reset_i, cmd_cpu_reset_i} <= cmd;
    endtask
    task automatic ctrl_idle;
        @(posedge sys_clk_i);
        ctrl_wr_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic status_read;
        @(posedge sys_clk_i);
        status_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        status_rd_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask
    // outside party pulls the line low, with the mode bits set alongside
    task automatic pin_low(input int n, input logic en, input logic ien);
        @(posedge sys_clk_i);
        pin_reset_enable_i <= en;
        pin_event_irq_enable_i <= ien;
        ext_hold <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task automatic bod(input int n, input logic en);
        @(posedge sys_clk_i);
        brownout_rst_en_i <= en;
        brownout_irq_enable_i <= 1'b1;
        brownout_req_i <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    // each cpu reset release is matched against the oldest note
    always @(negedge sys_clk_i) begin
        if (cpu_rst_n_o === 1'b1 && cpu_prev === 1'b0) begin
            if (exp_q.size() == 0) check(1'b0, "unexpected cpu reset release");
            else begin
                e = exp_q.pop_front();
                check(reset_cause_o === e.cause && cyc inside {[e.lo:e.hi]}, "release");
            end
        end
        cpu_prev = cpu_rst_n_o;
    end
    // main sequence
    initial begin
        void'($urandom(80798));
        repeat (20) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        exp_q.push_back('{srs_pkg::SRS_CAUSE_POR, cyc + 64, cyc + 68});
        repeat (80) @(posedge sys_clk_i);
        for (int i = 1; i < 8; i++) begin
            pulse_length_exp_i <= 4'($urandom_range(3));
            ctrl_write(srs_pkg::SRS_CTRL_KEY, 3'(i));
            if (i[0]) exp_q.push_back('{srs_pkg::SRS_CAUSE_SW, cyc + 5, cyc + 5});
            ctrl_write(srs_pkg::SRS_CTRL_KEY, 3'h1);
            ctrl_idle();
            check(cmd_in_progress_o === 1'b1 && periph_rst_n_o === !i[1], "periph cmd");
            check(cpu_rst_n_o === !i[0], "cpu command not applied");
            repeat (40) @(posedge sys_clk_i);
        end
        ctrl_write(8'($urandom_range(8'ha4)), 3'h1);
        ctrl_idle();
        check(cmd_in_progress_o === 1'b0 && cpu_rst_n_o === 1'b1, "bad key accepted");
        ctrl_write(srs_pkg::SRS_CTRL_KEY, 3'h0);
        ctrl_idle();
        check(cmd_in_progress_o === 1'b0, "empty command accepted");
        hold_len = $urandom_range(40, 10);
        status_read();
        pin_low(hold_len, 1'b1, 1'b0);
        check(cpu_rst_n_o === 1'b0 && periph_rst_n_o === 1'b0, "no user reset");
        check(pin_event_flag_o === 1'b1, "pin flag not set");
        @(posedge sys_clk_i);
        ext_hold <= 1'b0;
        exp_q.push_back('{srs_pkg::SRS_CAUSE_USER, cyc + 6, cyc + 6});
        repeat (10) @(posedge sys_clk_i);
        status_read();
        check(pin_event_flag_o === 1'b0, "pin flag not cleared");
        check(reset_cause_o === srs_pkg::SRS_CAUSE_USER, "cause lost on read");
        pin_low(12, 1'b0, 1'b0);
        check(cpu_rst_n_o === 1'b1, "user reset while disabled");
        pin_low(12, 1'b1, 1'b1);
        check(cpu_rst_n_o === 1'b1 && irq_o === 1'b1, "pin interrupt path");
        @(posedge sys_clk_i);
        ext_hold <= 1'b0;
        status_read();
        @(negedge sys_clk_i);
        check(irq_o === 1'b0, "pin interrupt not cleared");
        bod(6, 1'b0);
        check(cpu_rst_n_o === 1'b1 && brownout_flag_o === 1'b1, "brownout flag");
        check(irq_o === 1'b1, "brownout interrupt missing");
        @(posedge sys_clk_i);
        brownout_req_i <= 1'b0;
        status_read();
        check(brownout_flag_o === 1'b0, "brownout flag not cleared");
        bod(8, 1'b1);
        check(cpu_rst_n_o === 1'b0 && periph_rst_n_o === 1'b0, "no brownout reset");
        @(posedge sys_clk_i);
        brownout_req_i <= 1'b0;
        exp_q.push_back('{srs_pkg::SRS_CAUSE_BOD, cyc + 6, cyc + 6});
        repeat (40) @(posedge sys_clk_i);
        core_supply_ok_i <= 1'b0;
        #1;
        check(cpu_rst_n_o === 1'b0 && pin_oe_o === 1'b1 && pin_out_o === 1'b0,
            "supply loss not immediate");
        repeat (3) @(posedge sys_clk_i);
        core_supply_ok_i <= 1'b1;
        exp_q.push_back('{srs_pkg::SRS_CAUSE_POR, cyc + 64, cyc + 68});
        repeat (90) @(posedge sys_clk_i);
        check(exp_q.size() == 0, "missing reset release");
        // enable low: pin pulled low must leave level bit and flag frozen
        status_read();
        clk_en_i <= 1'b0;
        ext_hold <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check(pin_event_flag_o === 1'b0 && pin_level_bit_o === 1'b1, "not frozen");
        summarize();
    end
    // watchdog against a hang
    initial begin
        #100us;
        mismatches++;
        summarize();
    end
endmodule
